/* File: verilog/asp_port.sv */
// Purpose: Device side of the converter serial port and its ready signalling.
// Assumes: Host drives the link clock; clk_sys samples it through two flops.
// Notes:   Serial clock edges are found in the system domain.
//
// Contract
// - Bursty serial clock keeps transfer position.
// - Select low enables serial participation.
// - Select tied low still works fully.
// - Conversion completion drives ready pin low, except during a read.
// - Unread result releases ready before update.
// - Output bit shifted on clock falling.
// - Select high tristates pin, flag continues.
// - Ready flag kept in status register.
// - Output shifter loads any addressed register.
// - Input shifter writes only the mode or filter register.
// - Command byte first, then back to command.
// - Thirty-two ones reset the whole device.
// - Leading one holds command bit position.
// - Reading result returns ready high.
`timescale 1ns/1ps
module asp_port (
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire asp_pkg::asp_pins_t   pins,
    input  wire logic                 conv_done,
    input  wire logic [23:0]          conv_result,
    input  wire logic                 update_soon,
    output asp_pkg::asp_pin_out_t     pin_out,
    output logic                      ready_n,
    output logic [7:0]                mode_reg,
    output logic [7:0]                filter_reg,
    output logic [7:0]                cmd_reg,
    output logic                      part_reset
);
    import asp_pkg::*;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_WRITE,
        ST_READ
    } asp_phase_t;

    typedef struct packed {
        asp_phase_t   phase;
        logic [4:0]   cnt;
        logic [5:0]   ones;
        logic [7:0]   cmd;
        logic [23:0]  sh_in;
        logic [23:0]  sh_out;
        logic [7:0]   mode;
        logic [7:0]   filt;
        logic [23:0]  data;
        logic         rdy_n;
        logic         dout;
        logic         oe_n;
        logic         srst;
        logic         sclk_prev;
    } asp_state_t;

    localparam asp_state_t RESET_STATE = '{
        phase: ST_CMD, cnt: 5'h00, ones: 6'h00, cmd: CMD_RESET,
        sh_in: 24'h000000, sh_out: 24'h000000, mode: MODE_RESET,
        filt: FILTER_RESET, data: DATA_RESET,
        rdy_n: STATUS_RESET[STATUS_RDY_BIT], dout: 1'b1, oe_n: 1'b1,
        srst: 1'b0, sclk_prev: 1'b1};

    function automatic logic [4:0] reg_last(input logic [1:0] rs);
        reg_last = (rs == RS_DATA) ? WORD_LAST : BYTE_LAST;
    endfunction

    asp_pins_t  sp;
    asp_state_t st_q;
    asp_state_t st_d;
    logic       rise;
    logic       fall;
    logic [1:0] rs;
    logic [7:0] status_val;

    asp_sync u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .raw     (pins),
        .synced  (sp)
    );

    // Edges count only while selected; a high select merely pauses the transfer.
    assign rise       = sp.sclk && !st_q.sclk_prev && !sp.cs_n;
    assign fall       = !sp.sclk && st_q.sclk_prev && !sp.cs_n;
    assign rs         = st_q.cmd[CMD_RS_HI:CMD_RS_LO];
    assign status_val = {st_q.rdy_n, STATUS_RESET[6:0]};

    always_comb begin
        logic [7:0]  new_cmd;
        logic [23:0] shifted;
        new_cmd          = {st_q.sh_in[6:0], sp.din};
        shifted          = {st_q.sh_in[22:0], sp.din};
        st_d             = st_q;
        st_d.sclk_prev   = sp.sclk;
        st_d.srst        = 1'b0;
        st_d.oe_n        = sp.cs_n;

        if (rise) begin
            st_d.sh_in = shifted;
            case (st_q.phase)
                ST_CMD: begin
                    if (st_q.cnt == 5'h00 && sp.din) begin
                        st_d.cnt = 5'h00;
                    end else if (st_q.cnt == BYTE_LAST) begin
                        st_d.cmd = new_cmd;
                        st_d.cnt = 5'h00;
                        if (new_cmd[CMD_READ_BIT]) begin
                            st_d.phase = ST_READ;
                            case (new_cmd[CMD_RS_HI:CMD_RS_LO])
                                RS_STATUS: st_d.sh_out = {status_val, 16'h0000};
                                RS_MODE:   st_d.sh_out = {st_q.mode, 16'h0000};
                                RS_FILTER: st_d.sh_out = {st_q.filt, 16'h0000};
                                default:   st_d.sh_out = st_q.data;
                            endcase
                        end else if (new_cmd[CMD_RS_HI:CMD_RS_LO] == RS_STATUS) begin
                            st_d.phase = ST_CMD;
                        end else begin
                            st_d.phase = ST_WRITE;
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + 5'h01;
                    end
                end
                ST_WRITE: begin
                    if (st_q.cnt == reg_last(rs)) begin
                        st_d.cnt   = 5'h00;
                        st_d.phase = ST_CMD;
                        if (rs == RS_MODE) begin
                            st_d.mode = shifted[7:0];
                        end else if (rs == RS_FILTER) begin
                            st_d.filt = shifted[7:0];
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + 5'h01;
                    end
                end
                default: begin
                    if (st_q.cnt == reg_last(rs)) begin
                        st_d.cnt   = 5'h00;
                        st_d.phase = ST_CMD;
                        if (rs == RS_DATA) begin
                            st_d.rdy_n = 1'b1;
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + 5'h01;
                    end
                end
            endcase
            if (!sp.din) begin
                st_d.ones = 6'h00;
            end else if (st_q.ones != RESET_ONES) begin
                st_d.ones = st_q.ones + 6'h01;
            end
        end

        if (fall && st_q.phase == ST_READ) begin
            st_d.dout   = st_q.sh_out[23];
            st_d.sh_out = {st_q.sh_out[22:0], 1'b0};
        end else if (st_q.phase != ST_READ) begin
            st_d.dout = st_d.rdy_n;
        end

        // The flag keeps tracking conversions whether or not the pin is driven.
        if (update_soon) begin
            st_d.rdy_n = 1'b1;
        end
        if (conv_done) begin
            st_d.rdy_n = 1'b0;
            st_d.data  = conv_result;
            if (st_q.phase != ST_READ) begin
                st_d.dout = 1'b0;
            end
        end

        if (st_d.ones == RESET_ONES) begin
            st_d      = RESET_STATE;
            st_d.srst = 1'b1;
            st_d.oe_n = sp.cs_n;
            st_d.sclk_prev = sp.sclk;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_q <= RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_out.dout      = st_q.dout;
    assign pin_out.dout_oe_n = st_q.oe_n;
    assign ready_n           = st_q.rdy_n;
    assign mode_reg          = st_q.mode;
    assign filter_reg        = st_q.filt;
    assign cmd_reg           = st_q.cmd;
    assign part_reset        = st_q.srst;

endmodule

/* File: verilog/asp_pkg.sv */
// Purpose: Shared constants and types for the converter serial port.
// Assumes: One system clock; the serial link pins are asynchronous to it.
// Notes:   Register widths and reset values live here only.
package asp_pkg;

    localparam logic [1:0] RS_STATUS = 2'h0;
    localparam logic [1:0] RS_MODE   = 2'h1;
    localparam logic [1:0] RS_FILTER = 2'h2;
    localparam logic [1:0] RS_DATA   = 2'h3;

    // Command byte fields, first bit received is bit 7.
    localparam int CMD_GATE_BIT = 7;
    localparam int CMD_RS_HI    = 5;
    localparam int CMD_RS_LO    = 4;
    localparam int CMD_READ_BIT = 3;

    localparam int STATUS_RDY_BIT = 7;

    localparam logic [7:0]  STATUS_RESET = 8'h8C;
    localparam logic [7:0]  MODE_RESET   = 8'h02;
    localparam logic [7:0]  FILTER_RESET = 8'h04;
    localparam logic [23:0] DATA_RESET   = 24'h000000;
    localparam logic [7:0]  CMD_RESET    = 8'h00;

    // Last bit index of a byte and of the result word.
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h17;

    // Rising serial clocks with the data input high that reset the part.
    localparam logic [5:0] RESET_ONES = 6'h20;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } asp_pins_t;

    typedef struct packed {
        logic       dout;
        logic       dout_oe_n;
    } asp_pin_out_t;

endpackage

/* File: verilog/asp_sync.sv */
// Purpose: Two-flop synchroniser for the serial link pins.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module asp_sync (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire asp_pkg::asp_pins_t raw,
    output asp_pkg::asp_pins_t     synced
);
    import asp_pkg::*;

    typedef struct packed {
        asp_pins_t s1;
        asp_pins_t s2;
    } asp_sync_state_t;

    localparam asp_pins_t IDLE = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};

    asp_sync_state_t st_q;
    asp_sync_state_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_q <= '{s1: IDLE, s2: IDLE};
        end else begin
            st_q <= st_d;
        end
    end

    assign synced = st_q.s2;

endmodule

/* File: dv/asp_port_props.sv */
// Purpose: Assertions on the converter serial port pins.
// Assumes: Sees only the ports of asp_port.
// Notes:   Latencies follow the two-flop pin synchroniser.
`timescale 1ns/1ps
module asp_port_props (
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    input wire asp_pkg::asp_pins_t    pins,
    input wire logic                  conv_done,
    input wire logic                  update_soon,
    input wire asp_pkg::asp_pin_out_t pin_out,
    input wire logic                  ready_n,
    input wire logic [7:0]            mode_reg,
    input wire logic [7:0]            filter_reg,
    input wire logic [7:0]            cmd_reg,
    input wire logic                  part_reset
);
    import asp_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_cs_idle;
        pins.cs_n [*6];
    endsequence
    AST_OE_LAG: assert property (pin_out.dout_oe_n == $past(pins.cs_n, 3))
        else $error("output enable does not follow select");
    AST_RDY_SET: assert property (conv_done |=> !ready_n)
        else $error("ready flag not set by conversion");
    AST_RDY_FALL: assert property ($fell(ready_n) |-> $past(conv_done))
        else $error("ready flag fell without conversion");
    AST_RDY_DROP: assert property (update_soon && !conv_done |=> ready_n)
        else $error("unread ready not released before update");
    AST_RDY_RISE: assert property ($rose(ready_n) |-> $past(update_soon) || !pin_out.dout_oe_n)
        else $error("ready flag rose without cause");
    AST_RST_PULSE: assert property (part_reset |=> !part_reset)
        else $error("part reset pulse too long");
    AST_RST_VALUES: assert property (part_reset |-> ##[0:1]
        (mode_reg == MODE_RESET && filter_reg == FILTER_RESET && cmd_reg == CMD_RESET))
        else $error("registers not at reset values");
    AST_CS_IDLE: assert property (s_cs_idle |-> $stable(cmd_reg) && $stable(mode_reg))
        else $error("register changed while deselected");
endmodule
bind asp_port asp_port_props i_props (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .pins        (pins),
    .conv_done   (conv_done),
    .update_soon (update_soon),
    .pin_out     (pin_out),
    .ready_n     (ready_n),
    .mode_reg    (mode_reg),
    .filter_reg  (filter_reg),
    .cmd_reg     (cmd_reg),
    .part_reset  (part_reset)
);

/* File: dv/asp_host_model.sv */
// Purpose: Serial master driving the converter port pins.
// Assumes: Link clock half period is 8 system clocks, idle high.
// Notes:   Data in is inverted whenever the select is released.
`timescale 1ns/1ps
module asp_host_model (
    input wire logic                  clk_sys,
    output asp_pkg::asp_pins_t        pins,
    input wire asp_pkg::asp_pin_out_t pin_out
);
    import asp_pkg::*;
    initial pins = 3'b111;
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic sel(input logic v);
        pins.cs_n <= v;
        if (v) pins.din <= ~pins.din;
        wait_clk(4);
    endtask
    // Waits for a falling edge on the driven ready pin, as an interrupt input would.
    task automatic wait_ready(input int limit, output logic seen);
        logic prev;
        prev = pin_out.dout;
        seen = 1'b0;
        repeat (limit) begin
            @(posedge clk_sys);
            if (!pin_out.dout_oe_n && prev && !pin_out.dout) seen = 1'b1;
            prev = pin_out.dout;
        end
    endtask
    // Bits may come in bursts of any length; the clock idles high between them.
    task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            pins.sclk <= 1'b0;
            pins.din  <= w[i];
            wait_clk(8);
            r = {r[30:0], pin_out.dout_oe_n ? 1'bz : pin_out.dout};
            pins.sclk <= 1'b1;
            wait_clk(8);
        end
    endtask
endmodule

/* File: dv/asp_port_bench.sv */
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model drives the link pins.
// Notes:   Each scenario is one task.
`timescale 1ns/1ps
module asp_port_bench;
    import asp_pkg::*;
    logic clk_sys = 0, resetn = 0, conv_done = 0, update_soon = 0;
    logic [23:0] conv_result = '0;
    asp_pins_t pins;
    asp_pin_out_t pin_out;
    logic ready_n, part_reset;
    logic [7:0] mode_reg, filter_reg, cmd_reg;
    logic [31:0] rd;
    int errors = 0, n_compared = 0;
    asp_port i_dut (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .pins        (pins),
        .conv_done   (conv_done),
        .conv_result (conv_result),
        .update_soon (update_soon),
        .pin_out     (pin_out),
        .ready_n     (ready_n),
        .mode_reg    (mode_reg),
        .filter_reg  (filter_reg),
        .cmd_reg     (cmd_reg),
        .part_reset  (part_reset)
    );
    asp_host_model i_host (
        .clk_sys (clk_sys),
        .pins    (pins),
        .pin_out (pin_out)
    );
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic pulse(input logic upd);
        @(posedge clk_sys);
        conv_done   <= !upd;
        update_soon <= upd;
        conv_result <= 24'hA5C3F0;
        @(posedge clk_sys);
        conv_done   <= 1'b0;
        update_soon <= 1'b0;
        i_host.wait_clk(2);
    endtask
    task automatic t_reset_values();
        check({ready_n, pin_out.dout_oe_n, part_reset, mode_reg, filter_reg, cmd_reg},
            {3'b110, MODE_RESET, FILTER_RESET, CMD_RESET});
    endtask
    task automatic t_write_bursts();
        i_host.sel(0);
        i_host.xfer(4, 4'h8, rd);
        i_host.sel(1);
        i_host.sel(0);
        i_host.xfer(5, 5'h10, rd);
        i_host.xfer(8, 8'h5A, rd);
        check({cmd_reg, mode_reg}, 16'h105A);
        i_host.sel(1);
    endtask
    task automatic t_three_wire();
        i_host.sel(0);
        i_host.xfer(16, 16'h2033, rd);
        i_host.xfer(16, 16'h10C3, rd);
        check({filter_reg, mode_reg}, 16'h33C3);
        i_host.xfer(16, 16'h1800, rd);
        check(rd[7:0], 8'hC3);
    endtask
    task automatic t_ready_read();
        logic seen;
        fork
            pulse(0);
            i_host.wait_ready(8, seen);
        join
        check(seen, 1'b1);
        check({ready_n, pin_out.dout}, 2'b00);
        i_host.xfer(16, 16'h0800, rd);
        check(rd[7:0], 8'h0C);
        i_host.xfer(32, 32'h38000000, rd);
        check(rd[23:0], 24'hA5C3F0);
        i_host.wait_clk(4);
        check(ready_n, 1'b1);
        i_host.sel(1);
        check(pin_out.dout_oe_n, 1'b1);
    endtask
    task automatic t_unread();
        pulse(0);
        check(ready_n, 1'b0);
        pulse(1);
        check(ready_n, 1'b1);
    endtask
    task automatic t_ones_reset();
        i_host.sel(0);
        i_host.xfer(32, 32'hFFFFFFFF, rd);
        i_host.wait_clk(4);
        check({mode_reg, filter_reg}, {MODE_RESET, FILTER_RESET});
        i_host.sel(1);
    endtask
    initial begin
        repeat (25000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        i_host.wait_clk(4);
        t_reset_values();
        t_write_bursts();
        t_three_wire();
        t_ready_read();
        t_unread();
        t_ones_reset();
        give_verdict();
    end
endmodule
